//--- core/tmr16_core.sv
// Purpose: 16-bit timer with capture, two compares, clock select
// Assumes: 8-bit I/O port; i_gie is the global interrupt enable
// Notes: prescaler is local and free running
// Summary of operation
// R01 - Edge select bit picks capture edge
// R02 - Capture copies counter, sets capture flag
// R03 - No pin capture when capture is TOP
// R04 - Reserved bits read zero
// R05 - Clock select stop, direct, prescaler taps
// R06 - Values 6 and 7 count external edges
// R07 - External pin counts regardless of direction
// R08 - Force compare acts in non-PWM only
// R09 - Forced compare sets no flag, no clear
// R10 - Force bits read zero
// R11 - Software writes force zero in PWM
// R12 - Shared high byte temp for 16-bit
// R13 - Counter write blocks next compare
// R14 - Compares counter against both registers
// R15 - Capture from pin or comparator
// R16 - Interrupt needs enable, global, flag
// R17 - Capture flag at TOP when capture TOP
// R18 - Compare flag set cycle after match
// R19 - Flags clear on vector or one
// R20 - Overflow flag per waveform mode
// R21 - Noise filter needs four equal samples
// R22 - Output mode off toggle clear set
// R23 - Force bit is pulse, not stored
`timescale 1ns/1ps
`include "tmr16_params.svh"
module tmr16_core (
  input  wire logic                i_sys_clk,     // System clock, 100 MHz
  input  wire logic                i_rst_b,       // Async reset, active low
  input  wire tmr16_pkg::tmr16_bus_s i_bus,       // I/O register access
  input  wire tmr16_pkg::tmr16_ack_s i_ack,       // Vector executed strobes
  input  wire logic                i_gie,         // Global interrupt enable
  input  wire logic                i_capture_input_pin, // Capture pin
  input  wire logic                i_comparator,  // Analog comparator out
  input  wire logic                i_cap_from_cmp, // Capture source select
  input  wire logic                i_external_count_pin, // Count pin
  output logic [7:0]               o_rdata,       // Read data
  output logic                     o_wave_out_a,  // Compare output A
  output logic                     o_wave_out_b,  // Compare output B
  output logic                     o_wave_en_a,   // Output A connected
  output logic                     o_wave_en_b,   // Output B connected
  output logic [3:0]               o_irq          // cap, cmpb, cmpa, ovf
);
  logic [7:0]  waveform_ctrl_a;
  logic [7:0]  clock_capture_ctrl;
  logic [7:0]  timer_irq_mask;
  logic [7:0]  timer_irq_flags;
  logic [7:0]  temp_high;
  logic [15:0] counter_value;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value;
  logic [9:0]  prescale;
  logic [9:0]  prescale_d;
  logic        tick;
  logic        cnt_written;
  logic        block_cmp;
  logic        match_a_q;
  logic        match_b_q;
  logic        pin_edge;
  logic        cmp_edge;
  logic        ext_edge;
  logic [3:0]  waveform_mode;
  logic [2:0]  clock_source_sel;
  logic        cap_is_top;
  logic        pwm_mode;
  logic [15:0] top_value;
  logic        at_top;
  logic        is_wr;
  logic        force_a;
  logic        force_b;
  logic        cap_event;
  logic        ovf_event;
  logic [15:0] next_counter;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [7:0]  next_rdata;

  assign waveform_mode    = {clock_capture_ctrl[4:3], waveform_ctrl_a[1:0]};
  assign clock_source_sel = clock_capture_ctrl[2:0];
  assign cap_is_top       = (waveform_mode == 4'hC) || (waveform_mode == 4'hE) ||
                            (waveform_mode == 4'h8) || (waveform_mode == 4'hA);
  assign pwm_mode         = !((waveform_mode == 4'h0) || (waveform_mode == 4'h4) ||
                              (waveform_mode == 4'hC));
  assign is_wr            = i_bus.wr;

  always_comb
  begin
    unique case (waveform_mode)
      4'h4, 4'h9, 4'hB, 4'hF: top_value = compare_value_a;
      4'h8, 4'hA, 4'hC, 4'hE: top_value = capture_value;
      4'h1, 4'h5:             top_value = 16'h00FF;
      4'h2, 4'h6:             top_value = 16'h01FF;
      4'h3, 4'h7:             top_value = 16'h03FF;
      default:                top_value = `TMR16_MAX;
    endcase
  end
  assign at_top = (counter_value == top_value);

  // External pin, capture pin and comparator conditioning
  tmr16_filter u_ext (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_pin     (i_external_count_pin), // R07
    .i_filt_en (1'b0),
    .i_rise    (clock_source_sel[0]),
    .o_edge    (ext_edge)
  );
  tmr16_filter u_cap (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_pin     (i_capture_input_pin),
    .i_filt_en (clock_capture_ctrl[`TMR16_BIT_NOISE]),
    .i_rise    (clock_capture_ctrl[`TMR16_BIT_EDGE]),
    .o_edge    (pin_edge)
  );
  tmr16_filter u_cmp (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_pin     (i_comparator),
    .i_filt_en (clock_capture_ctrl[`TMR16_BIT_NOISE]),
    .i_rise    (clock_capture_ctrl[`TMR16_BIT_EDGE]),
    .o_edge    (cmp_edge)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      prescale   <= 10'h000;
      prescale_d <= 10'h000;
    end
    else
    begin
      prescale   <= prescale + 10'h001;
      prescale_d <= prescale;
    end
  end

  always_comb
  begin
    unique case (clock_source_sel) // R05 R06
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = prescale[2] & ~prescale_d[2] ? 1'b0 : (prescale[2:0] == 3'h0);
      3'h3: tick = (prescale[5:0] == 6'h00);
      3'h4: tick = (prescale[7:0] == 8'h00);
      3'h5: tick = (prescale == 10'h000);
      3'h6, 3'h7: tick = ext_edge;
    endcase
  end

  assign force_a   = is_wr && (i_bus.addr == `TMR16_OFF_FORCE) &&
                     i_bus.wdata[`TMR16_BIT_FORCE_A] && !pwm_mode; // R08 R23
  assign force_b   = is_wr && (i_bus.addr == `TMR16_OFF_FORCE) &&
                     i_bus.wdata[`TMR16_BIT_FORCE_B] && !pwm_mode; // R08 R23
  assign cnt_written = is_wr && (i_bus.addr == `TMR16_OFF_CNT_LO);
  assign cap_event = cap_is_top ? (tick && at_top) : // R17
                     (i_cap_from_cmp ? cmp_edge : pin_edge); // R03 R15
  assign ovf_event = tick && (pwm_mode ? (at_top || counter_value == 16'h0000) :
                     (counter_value == `TMR16_MAX)); // R20

  always_comb
  begin
    next_counter = counter_value + 16'h0001;
    if (!pwm_mode && at_top && waveform_mode != 4'h0)
      next_counter = `TMR16_RST_WORD; // R09
    else if (pwm_mode && at_top)
      next_counter = `TMR16_RST_WORD;
  end

  // Counter and temp high byte
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      counter_value <= `TMR16_RST_WORD;
    else if (cnt_written)
      counter_value <= {temp_high, i_bus.wdata}; // R12
    else if (tick)
      counter_value <= next_counter;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      block_cmp <= 1'b0;
    else if (cnt_written)
      block_cmp <= 1'b1; // R13
    else if (tick)
      block_cmp <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      temp_high <= `TMR16_RST_BYTE;
    else if (is_wr && (i_bus.addr == `TMR16_OFF_CNT_HI || i_bus.addr == `TMR16_OFF_CMPA_HI ||
             i_bus.addr == `TMR16_OFF_CMPB_HI || i_bus.addr == `TMR16_OFF_CAP_HI))
      temp_high <= i_bus.wdata; // R12
    else if (i_bus.rd && i_bus.addr == `TMR16_OFF_CNT_LO)
      temp_high <= counter_value[15:8]; // R12
    else if (i_bus.rd && i_bus.addr == `TMR16_OFF_CAP_LO)
      temp_high <= capture_value[15:8];
  end

  // Control and compare registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      waveform_ctrl_a    <= `TMR16_RST_BYTE;
      clock_capture_ctrl <= `TMR16_RST_BYTE;
      timer_irq_mask     <= `TMR16_RST_BYTE;
      compare_value_a    <= `TMR16_RST_WORD;
      compare_value_b    <= `TMR16_RST_WORD;
    end
    else if (is_wr)
    begin
      if (i_bus.addr == `TMR16_OFF_WAVE_A)
        waveform_ctrl_a <= i_bus.wdata & 8'hF3;
      if (i_bus.addr == `TMR16_OFF_CLK_CAP)
        clock_capture_ctrl <= i_bus.wdata & `TMR16_CLK_CAP_MASK; // R04
      if (i_bus.addr == `TMR16_OFF_MASK)
        timer_irq_mask <= i_bus.wdata & `TMR16_FLAG_MASK; // R04
      if (i_bus.addr == `TMR16_OFF_CMPA_LO)
        compare_value_a <= {temp_high, i_bus.wdata}; // R12
      if (i_bus.addr == `TMR16_OFF_CMPB_LO)
        compare_value_b <= {temp_high, i_bus.wdata};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      capture_value <= `TMR16_RST_WORD;
    else if (cap_event && !cap_is_top)
      capture_value <= counter_value; // R02
    else if (is_wr && i_bus.addr == `TMR16_OFF_CAP_LO)
      capture_value <= {temp_high, i_bus.wdata};
  end

  // Compare match, delayed one system clock
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
    end
    else
    begin
      match_a_q <= tick && !block_cmp && !cnt_written && (counter_value == compare_value_a); // R14 R13
      match_b_q <= tick && !block_cmp && !cnt_written && (counter_value == compare_value_b); // R14 R13
    end
  end

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`TMR16_BIT_CAP]  = cap_event; // R02
    flag_set[`TMR16_BIT_CMPA] = match_a_q; // R18 R09
    flag_set[`TMR16_BIT_CMPB] = match_b_q; // R18 R09
    flag_set[`TMR16_BIT_OVF]  = ovf_event;
    flag_clr = 8'h00;
    if (is_wr && i_bus.addr == `TMR16_OFF_FLAGS)
      flag_clr = i_bus.wdata & `TMR16_FLAG_MASK; // R19
    flag_clr[`TMR16_BIT_CAP]  = flag_clr[`TMR16_BIT_CAP]  | i_ack.vec_cap;
    flag_clr[`TMR16_BIT_CMPB] = flag_clr[`TMR16_BIT_CMPB] | i_ack.vec_cmpb;
    flag_clr[`TMR16_BIT_CMPA] = flag_clr[`TMR16_BIT_CMPA] | i_ack.vec_cmpa;
    flag_clr[`TMR16_BIT_OVF]  = flag_clr[`TMR16_BIT_OVF]  | i_ack.vec_ovf;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      timer_irq_flags <= `TMR16_RST_BYTE;
    else
      timer_irq_flags <= ((timer_irq_flags & ~flag_clr) | flag_set) & `TMR16_FLAG_MASK; // R19 R04
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_irq <= 4'h0;
    else
      o_irq <= {4{i_gie}} & {timer_irq_flags[5], timer_irq_flags[2:0]} &
               {timer_irq_mask[5], timer_irq_mask[2:0]}; // R16
  end

  // Waveform outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_wave_out_a <= 1'b0;
      o_wave_out_b <= 1'b0;
      o_wave_en_a  <= 1'b0;
      o_wave_en_b  <= 1'b0;
    end
    else
    begin
      o_wave_en_a <= (waveform_ctrl_a[7:6] != 2'h0);
      o_wave_en_b <= (waveform_ctrl_a[5:4] != 2'h0);
      if (match_a_q || force_a)
        unique case (tmr16_pkg::tmr16_com_e'(waveform_ctrl_a[7:6])) // R22 R08
          tmr16_pkg::TMR16_OUT_OFF:    o_wave_out_a <= o_wave_out_a;
          tmr16_pkg::TMR16_OUT_TOGGLE: o_wave_out_a <= ~o_wave_out_a;
          tmr16_pkg::TMR16_OUT_CLEAR:  o_wave_out_a <= 1'b0;
          tmr16_pkg::TMR16_OUT_SET:    o_wave_out_a <= 1'b1;
        endcase
      if (match_b_q || force_b)
        unique case (tmr16_pkg::tmr16_com_e'(waveform_ctrl_a[5:4])) // R22 R08
          tmr16_pkg::TMR16_OUT_OFF:    o_wave_out_b <= o_wave_out_b;
          tmr16_pkg::TMR16_OUT_TOGGLE: o_wave_out_b <= ~o_wave_out_b;
          tmr16_pkg::TMR16_OUT_CLEAR:  o_wave_out_b <= 1'b0;
          tmr16_pkg::TMR16_OUT_SET:    o_wave_out_b <= 1'b1;
        endcase
    end
  end

  // Read mux, registered
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (i_bus.addr)
      `TMR16_OFF_FLAGS:   next_rdata = timer_irq_flags;
      `TMR16_OFF_MASK:    next_rdata = timer_irq_mask;
      `TMR16_OFF_FORCE:   next_rdata = 8'h00; // R10
      `TMR16_OFF_CAP_LO:  next_rdata = capture_value[7:0];
      `TMR16_OFF_CAP_HI:  next_rdata = temp_high;
      `TMR16_OFF_CNT_LO:  next_rdata = counter_value[7:0];
      `TMR16_OFF_CNT_HI:  next_rdata = temp_high;
      `TMR16_OFF_CMPA_LO: next_rdata = compare_value_a[7:0];
      `TMR16_OFF_CMPA_HI: next_rdata = compare_value_a[15:8];
      `TMR16_OFF_CMPB_LO: next_rdata = compare_value_b[7:0];
      `TMR16_OFF_CMPB_HI: next_rdata = compare_value_b[15:8];
      `TMR16_OFF_WAVE_A:  next_rdata = waveform_ctrl_a;
      `TMR16_OFF_CLK_CAP: next_rdata = clock_capture_ctrl;
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= `TMR16_RST_BYTE;
    else if (i_bus.rd)
      o_rdata <= next_rdata;
  end

  property p_force_no_flag;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (force_a && !match_a_q) |=> !$rose(timer_irq_flags[1]) || $past(match_a_q);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("forced compare set flag"); // R09

  property p_cmp_flag;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    match_b_q |=> timer_irq_flags[2];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare B flag not set"); // R18

  property p_block;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    cnt_written |=> !match_a_q && !match_b_q;
  endproperty
  a_block: assert property (p_block) else $error("match after counter write"); // R13

  property p_capture;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (cap_event && !cap_is_top) |=> capture_value == $past(counter_value) && timer_irq_flags[5];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missing"); // R02

  property p_resv;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    ((timer_irq_flags & 8'hD8) == 8'h00) && ((timer_irq_mask & 8'hD8) == 8'h00);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set"); // R04

  property p_irq;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_gie && timer_irq_flags[0] && timer_irq_mask[0]) |=> o_irq[0];
  endproperty
  a_irq: assert property (p_irq) else $error("overflow irq missing"); // R16

  property p_stop;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (clock_source_sel == 3'h0 && !cnt_written) |=> $stable(counter_value);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved"); // R05

  property p_w1c;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (is_wr && i_bus.addr == `TMR16_OFF_FLAGS && i_bus.wdata[0] && !ovf_event) |=> !timer_irq_flags[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared"); // R19
endmodule

//--- core/tmr16_filter.sv
// Purpose: sync, optional noise filter and edge strobe for one pin
// Assumes: asynchronous pin input
// Notes: output pulse one cycle per selected edge
`timescale 1ns/1ps
`include "tmr16_params.svh"
module tmr16_filter (
  input  wire logic i_sys_clk,   // System clock
  input  wire logic i_rst_b,     // Async reset, active low
  input  wire logic i_pin,       // Raw pin level
  input  wire logic i_filt_en,   // Enable four-sample filter
  input  wire logic i_rise,      // 1 rising, 0 falling edge
  output logic      o_edge       // One-cycle edge strobe
);
  logic       sync_a;
  logic       sync_b;
  logic [3:0] hist;
  logic       level;
  logic       level_d;
  logic       next_level;

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= i_pin;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      hist <= 4'h0;
    else
      hist <= {hist[2:0], sync_b};
  end

  always_comb
  begin
    next_level = level;
    if (!i_filt_en)
      next_level = sync_b;
    else if (hist == 4'hF)
      next_level = 1'b1; // R21
    else if (hist == 4'h0)
      next_level = 1'b0; // R21
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      level   <= 1'b0;
      level_d <= 1'b0;
      o_edge  <= 1'b0;
    end
    else
    begin
      level   <= next_level;
      level_d <= level;
      o_edge  <= i_rise ? (level & ~level_d) : (~level & level_d); // R01 R06
    end
  end
endmodule

//--- core/tmr16_params.svh
// Purpose: constants for the 16-bit timer block
// Assumes: 8-bit I/O register port, byte offsets as listed
// Notes: offsets without a printed value are local choices
`ifndef TMR16_PARAMS_SVH
`define TMR16_PARAMS_SVH
`define TMR16_ADDR_W         6
`define TMR16_OFF_FLAGS      6'h0B
`define TMR16_OFF_MASK       6'h0C
`define TMR16_OFF_FORCE      6'h22
`define TMR16_OFF_CAP_LO     6'h24
`define TMR16_OFF_CAP_HI     6'h25
`define TMR16_OFF_WAVE_A     6'h2F
`define TMR16_OFF_CLK_CAP    6'h2E
`define TMR16_OFF_CNT_LO     6'h2C
`define TMR16_OFF_CNT_HI     6'h2D
`define TMR16_OFF_CMPA_LO    6'h2A
`define TMR16_OFF_CMPA_HI    6'h2B
`define TMR16_OFF_CMPB_LO    6'h28
`define TMR16_OFF_CMPB_HI    6'h29
`define TMR16_BIT_CAP        5
`define TMR16_BIT_CMPB       2
`define TMR16_BIT_CMPA       1
`define TMR16_BIT_OVF        0
`define TMR16_FLAG_MASK      8'h27
`define TMR16_BIT_FORCE_A    7
`define TMR16_BIT_FORCE_B    6
`define TMR16_BIT_NOISE      7
`define TMR16_BIT_EDGE       6
`define TMR16_CLK_CAP_MASK   8'hDF
`define TMR16_FILTER_LEN     4
`define TMR16_RST_BYTE       8'h00
`define TMR16_RST_WORD       16'h0000
`define TMR16_MAX            16'hFFFF
`endif

//--- core/tmr16_pkg.sv
// Purpose: shared types for the 16-bit timer block
// Assumes: used with tmr16_params.svh
// Notes: none
package tmr16_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tmr16_bus_s;
  typedef struct packed {
    logic vec_cap;
    logic vec_cmpb;
    logic vec_cmpa;
    logic vec_ovf;
  } tmr16_ack_s;
  typedef enum logic [1:0] {
    TMR16_OUT_OFF,
    TMR16_OUT_TOGGLE,
    TMR16_OUT_CLEAR,
    TMR16_OUT_SET
  } tmr16_com_e;
endpackage

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the 16-bit timer
// Assumes: host model drives bus and pins
// Notes: counter stopped except where a case runs it
`timescale 1ns/1ps
`include "tmr16_params.svh"
module tb_top;
  typedef struct packed { logic [5:0] a; logic [7:0] d; logic [7:0] e; } tmr16_row_s;
  logic                  sys_clk;
  logic                  rst_b;
  tmr16_pkg::tmr16_bus_s bus;
  tmr16_pkg::tmr16_ack_s ack;
  logic [4:0]            pins;
  logic [7:0]            rdata;
  logic                  wave_a;
  logic                  wave_b;
  logic                  en_a;
  logic                  en_b;
  logic [3:0]            irq;
  logic [7:0]            b;
  logic [15:0]           v;
  int                    mismatches;
  int                    tests_run;
  tmr16_row_s            rows [6];
  int                    cs_lo [6] = '{0, 126, 14, 1, 0, 0};
  int                    cs_hi [6] = '{0, 134, 18, 3, 1, 1};
  logic [1:0]            com_tab [3] = '{2'b10, 2'b11, 2'b01};
  logic [5:0]            rst_tab [7];
  tmr16_host_model tmr16_host_model_inst (
    .i_sys_clk (sys_clk),
    .i_rdata   (rdata),
    .o_bus     (bus),
    .o_ack     (ack),
    .o_pins    (pins)
  );
  tmr16_core tmr16_core_inst (
    .i_sys_clk            (sys_clk),
    .i_rst_b              (rst_b),
    .i_bus                (bus),
    .i_ack                (ack),
    .i_gie                (pins[4]),
    .i_capture_input_pin  (pins[1]),
    .i_comparator         (pins[2]),
    .i_cap_from_cmp       (pins[3]),
    .i_external_count_pin (pins[0]),
    .o_rdata              (rdata),
    .o_wave_out_a         (wave_a),
    .o_wave_out_b         (wave_b),
    .o_wave_en_a          (en_a),
    .o_wave_en_b          (en_b),
    .o_irq                (irq)
  );
  always #5 sys_clk = ~sys_clk;
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #300000;
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    sys_clk    = 1'b0;
    rst_b      = 1'b0;
    mismatches = 0;
    tests_run  = 0;
    rows = '{'{`TMR16_OFF_MASK, 8'hFF, 8'h27}, '{`TMR16_OFF_FLAGS, 8'hFF, 8'h00},
             '{`TMR16_OFF_FORCE, 8'hC0, 8'h00}, '{`TMR16_OFF_CAP_LO, 8'h5A, 8'h5A},
             '{`TMR16_OFF_CLK_CAP, 8'hE0, 8'hC0}, '{6'h3F, 8'hAA, 8'h00}};
    rst_tab = '{`TMR16_OFF_MASK, `TMR16_OFF_FLAGS, `TMR16_OFF_CLK_CAP, `TMR16_OFF_CMPA_LO,
                `TMR16_OFF_CMPA_HI, `TMR16_OFF_CAP_LO, `TMR16_OFF_CAP_HI};
    repeat (20) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      tmr16_host_model_inst.wr8(rows[i].a, rows[i].d);
      tmr16_host_model_inst.rd8(rows[i].a, b);
      check_val(b, rows[i].e);
    end
    // Compare A, overflow, interrupts and vector clear
    tmr16_host_model_inst.wr16(`TMR16_OFF_CMPA_LO, 16'hFFF8);
    tmr16_host_model_inst.wr16(`TMR16_OFF_CMPB_LO, 16'h8000);
    tmr16_host_model_inst.wr8(`TMR16_OFF_MASK, 8'h03);
    tmr16_host_model_inst.wr8(`TMR16_OFF_WAVE_A, 8'h40);
    tmr16_host_model_inst.set_pins(5'h10);
    tmr16_host_model_inst.wr16(`TMR16_OFF_CNT_LO, 16'hFFF0);
    tmr16_host_model_inst.wr8(`TMR16_OFF_CLK_CAP, 8'h01);
    repeat (40) @(posedge sys_clk);
    tmr16_host_model_inst.wr8(`TMR16_OFF_CLK_CAP, 8'h00);
    tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
    check_val(b, 8'h03);
    check_val(irq, 4'h3);
    check_val({en_b, wave_b, en_a, wave_a}, 4'h3);
    tmr16_host_model_inst.set_pins(5'h00);
    tmr16_host_model_inst.vector(4'h6);
    check_val(irq, 4'h0);
    tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
    check_val(b, 8'h01);
    tmr16_host_model_inst.wr8(`TMR16_OFF_FLAGS, 8'h01);
    tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
    check_val(b, 8'h00);
    // Forced compare on both channels, clear, set and toggle actions
    for (int i = 0; i < 3; i++)
    begin
      tmr16_host_model_inst.wr8(`TMR16_OFF_WAVE_A, {com_tab[i], com_tab[i], 4'h0});
      tmr16_host_model_inst.force_cmp(2'b11, 1'b0);
      tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
      check_val(b, 8'h00);
      check_val({wave_b, wave_a}, {2{i == 1}});
    end
    tmr16_host_model_inst.wr8(`TMR16_OFF_WAVE_A, 8'h00);
    // Internal clock sources
    for (int i = 0; i < 6; i++)
    begin
      tmr16_host_model_inst.wr16(`TMR16_OFF_CNT_LO, 16'h0000);
      tmr16_host_model_inst.wr8(`TMR16_OFF_CLK_CAP, 8'(i));
      repeat (128) @(posedge sys_clk);
      tmr16_host_model_inst.wr8(`TMR16_OFF_CLK_CAP, 8'h00);
      tmr16_host_model_inst.rd16(`TMR16_OFF_CNT_LO, v);
      check_val(16'(v >= cs_lo[i] && v <= cs_hi[i]), 16'h0001);
    end
    // External count pin, falling then rising edge select
    for (int i = 6; i < 8; i++)
    begin
      tmr16_host_model_inst.wr16(`TMR16_OFF_CNT_LO, 16'h0000);
      tmr16_host_model_inst.wr8(`TMR16_OFF_CLK_CAP, 8'(i));
      tmr16_host_model_inst.set_pins(5'h01);
      repeat (8) @(posedge sys_clk);
      tmr16_host_model_inst.rd16(`TMR16_OFF_CNT_LO, v);
      check_val(v, 16'(i == 7));
      tmr16_host_model_inst.set_pins(5'h00);
      repeat (8) @(posedge sys_clk);
      tmr16_host_model_inst.rd16(`TMR16_OFF_CNT_LO, v);
      check_val(v, 16'h0001);
    end
    // Capture on each edge select, wrong edge first for falling select
    for (int e = 0; e < 2; e++)
    begin
      tmr16_host_model_inst.wr8(`TMR16_OFF_CLK_CAP, {1'b0, e[0], 6'h00});
      tmr16_host_model_inst.wr16(`TMR16_OFF_CNT_LO, 16'h0A50 + 16'(e));
      tmr16_host_model_inst.wr8(`TMR16_OFF_FLAGS, 8'h27);
      tmr16_host_model_inst.set_pins(e ? 5'h00 : 5'h02);
      repeat (12) @(posedge sys_clk);
      tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
      check_val(b, 8'h00);
      tmr16_host_model_inst.set_pins(e ? 5'h02 : 5'h00);
      repeat (12) @(posedge sys_clk);
      tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
      check_val(b, 8'h20);
      tmr16_host_model_inst.rd16(`TMR16_OFF_CAP_LO, v);
      check_val(v, 16'h0A50 + 16'(e));
    end
    // Capture from the comparator
    tmr16_host_model_inst.wr8(`TMR16_OFF_FLAGS, 8'h27);
    tmr16_host_model_inst.set_pins(5'h08);
    tmr16_host_model_inst.set_pins(5'h0C);
    repeat (12) @(posedge sys_clk);
    tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
    check_val(b, 8'h20);
    tmr16_host_model_inst.vector(4'h9);
    tmr16_host_model_inst.rd8(`TMR16_OFF_FLAGS, b);
    check_val(b, 8'h00);
    // Second reset in mid-run
    @(posedge sys_clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    check_val({en_a, wave_a, en_b, wave_b, irq}, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      tmr16_host_model_inst.rd8(rst_tab[i], b);
      check_val(b, 8'h00);
    end
    tally_and_finish();
  end
endmodule

//--- testbench/tmr16_host_model.sv
// Purpose: processor and pin side model for the 16-bit timer
// Assumes: tasks drive 1 ns after a rising clock edge
// Notes: keeps the byte order of 16-bit accesses
`timescale 1ns/1ps
`include "tmr16_params.svh"
module tmr16_host_model (
  input  wire logic             i_sys_clk, // System clock
  input  wire logic [7:0]       i_rdata,   // Read data
  output tmr16_pkg::tmr16_bus_s o_bus,     // Register access
  output tmr16_pkg::tmr16_ack_s o_ack,     // Vector strobes
  output logic [4:0]            o_pins     // gie, cap src, comparator, cap pin, count pin
);
  initial
  begin
    o_bus  = '0;
    o_ack  = '0;
    o_pins = 5'h00;
  end
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_sys_clk);
    #1;
    o_bus = '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(posedge i_sys_clk);
    #1;
    o_bus = '0;
    q     = i_rdata;
  endtask
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rd8(input logic [5:0] a, output logic [7:0] q);
    access(1'b0, a, 8'h00, q);
  endtask
  task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
    wr8(lo + 6'h01, v[15:8]);
    wr8(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 6'h01, v[15:8]);
  endtask
  task automatic force_cmp(input logic [1:0] f, input logic pwm);
    wr8(`TMR16_OFF_FORCE, pwm ? 8'h00 : {f, 6'h00});
  endtask
  task automatic set_pins(input logic [4:0] p);
    @(posedge i_sys_clk);
    #1;
    o_pins = p;
  endtask
  task automatic vector(input logic [3:0] a);
    @(posedge i_sys_clk);
    #1;
    o_ack = a;
    @(posedge i_sys_clk);
    #1;
    o_ack = '0;
  endtask
endmodule
